/* common/capture_pkg.sv */
`default_nettype none
package capture_pkg;
	// ==================================================
	// Bus layout
	localparam int AXI_ADDR_W = 8;
	localparam int AXI_DATA_W = 32;
	localparam logic [7:0] ADDR_CONTROL_ONE = 8'h00;
	localparam logic [7:0] ADDR_CONTROL_TWO = 8'h04;
	localparam logic [7:0] ADDR_FIFO_LOW = 8'h08;
	localparam logic [7:0] ADDR_FIFO_HIGH = 8'h0C;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==================================================
	// Control one fields
	localparam int CTL1_IDLE_STOP = 13;
	localparam int CTL1_TSEL_LSB = 10;
	localparam int CTL1_ICI_LSB = 5;
	localparam int CTL1_OVF = 4;
	localparam int CTL1_BNE = 3;
	localparam int CTL1_MODE_LSB = 0;
	localparam logic [15:0] CTL1_WMASK = 16'h3C67;
	localparam logic [15:0] CTL1_RESET = 16'h0000;

	// ==================================================
	// Control two fields
	localparam int CTL2_CASCADE = 8;
	localparam int CTL2_TRIG_MODE = 7;
	localparam int CTL2_TRIG_STAT = 6;
	localparam int CTL2_SYNC_LSB = 0;
	localparam logic [15:0] CTL2_WMASK = 16'h01DF;
	localparam logic [15:0] CTL2_RESET = 16'h0000;

	// ==================================================
	// Time base selections that have no source
	localparam logic [2:0] TSEL_RSVD_A = 3'h5;
	localparam logic [2:0] TSEL_RSVD_B = 3'h6;

	// ==================================================
	// Capture store and counts
	localparam int FIFO_AW = 2;
	localparam int FIFO_DW = 32;
	localparam logic [2:0] FIFO_DEPTH = 3'h4;
	localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
	localparam logic [3:0] PRESCALE_16_LAST = 4'hF;

	// ==================================================
	// Capture modes
	typedef enum logic [2:0] {
		MODE_OFF = 3'b000,
		MODE_EVERY_EDGE = 3'b001,
		MODE_FALLING = 3'b010,
		MODE_RISING = 3'b011,
		MODE_RISE_4 = 3'b100,
		MODE_RISE_16 = 3'b101,
		MODE_RESERVED = 3'b110,
		MODE_WAKE_PIN = 3'b111
	} capture_mode_type;

	// Write channel states
	typedef enum logic [0:0] {
		WR_COLLECT = 1'b0,
		WR_RESP = 1'b1
	} write_state_type;
endpackage
`default_nettype wire

/* tb/capture_pin_model.sv */
`default_nettype none
module capture_pin_model (
	input wire logic clk,
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pin = 1'h0;
	// Full periods of w cycles per level; the line rests low between bursts
	task automatic pulse(input int n, input int w);
		repeat (n) begin
			@(posedge clk);
			pin <= 1'h1;
			repeat (w) @(posedge clk);
			pin <= 1'h0;
			repeat (w - 1) @(posedge clk);
		end
		// Let the two-flop sync and the flags settle
		repeat (8) @(posedge clk);
	endtask
endmodule
`default_nettype wire

/* tb/edge_capture_unit_asserts.sv */
`default_nettype none
module edge_capture_unit_asserts (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import capture_pkg::*;
	// ====================
	// Register bus timing
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Addresses past the last register or off a word boundary are refused
	function automatic logic bad(input logic [7:0] a);
		return a > 8'h0C || a[1:0] != 2'h0;
	endfunction
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid
		&& s_axi_bresp == (bad($past(s_axi_awaddr)) ? RESP_SLVERR : RESP_OKAY))
		else $error("write answer late or wrong");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
		&& s_axi_rresp == (bad($past(s_axi_araddr)) ? RESP_SLVERR : RESP_OKAY))
		else $error("read answer late or wrong");
	a_bresp_holds: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_rdata_holds: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_b_release: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
		else $error("upper read half not zero");
	a_bad_rdata: assert property (
		s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("refused read returned data");
	a_ce_freeze: assert property (
		!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
		else $error("bus ready while frozen");
endmodule
`default_nettype wire

/* tb/edge_capture_unit_tb_top.sv */
`default_nettype none
module edge_capture_unit_tb_top import capture_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_b, ce, capture_input_pin, idle_req, sleep_req, capture_irq;
	logic [7:0] tb_tick, tb_enabled, s_axi_awaddr, s_axi_araddr;
	logic [31:0] src_pulse, src_enabled, s_axi_wdata, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	int bad_count = 0;
	int tests_run = 0;
	int irq_n = 0;
	edge_capture_unit dut_u (.*);
	capture_pin_model pin_u (.clk(clk), .pin(capture_input_pin));
	// ====================
	// Clock, irq count, watchdog
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) if (capture_irq === 1'h1) irq_n++;
	initial begin
		repeat (90000) @(posedge clk);
		bad_count++;
		stop_test;
	end
	// ====================
	// Bus master and checks
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Ready is sampled mid-cycle so it matches what the next edge sees
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] q);
		logic ta, tw, tb;
		int n;
		n = 0;
		tb = 1'h0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!tb && n < 50) begin
			@(negedge clk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid;
			q = s_axi_bresp;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
			n++;
		end
		// A write that never gets its answer counts against the run
		if (!tb) bad_count++;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] q);
		logic ta, tb;
		int n;
		n = 0;
		tb = 1'h0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (!tb && n < 50) begin
			@(negedge clk);
			ta = s_axi_arvalid & s_axi_arready;
			tb = s_axi_rvalid;
			d = s_axi_rdata;
			q = s_axi_rresp;
			@(posedge clk);
			if (ta) s_axi_arvalid <= 1'h0;
			n++;
		end
		// A read that never gets its answer counts against the run
		if (!tb) bad_count++;
		s_axi_rready <= 1'h0;
	endtask
	// One tick pulse of time base b per call round
	task automatic tick(input int b, input int n);
		repeat (n) begin
			@(posedge clk);
			tb_tick <= 8'h01 << b;
			@(posedge clk);
			tb_tick <= 8'h00;
		end
	endtask
	// Source off first, stale data out, source on last
	task automatic cfg(input logic [15:0] c1, input logic [15:0] c2, input int s);
		int n;
		n = 0;
		src_enabled <= 32'h0000_0000;
		rd(ADDR_CONTROL_ONE, v, r);
		while (v[CTL1_BNE] === 1'h1 && n < 8) begin
			rd(ADDR_FIFO_LOW, v, r);
			rd(ADDR_CONTROL_ONE, v, r);
			n++;
		end
		chk(v[CTL1_BNE], 1'h0);
		wr(ADDR_CONTROL_TWO, {16'h0000, c2}, r);
		wr(ADDR_CONTROL_ONE, {16'h0000, c1}, r);
		src_enabled[s] <= 1'h1;
		irq_n = 0;
	endtask
	// ====================
	// Scenarios
	task automatic t_regs;
		// Frozen clock enable: every ready must drop while ce is low
		@(posedge clk);
		ce <= 1'h0;
		repeat (3) @(posedge clk);
		ce <= 1'h1;
		rd(ADDR_CONTROL_ONE, v, r);
		chk(v, CTL1_RESET);
		wr(ADDR_CONTROL_ONE, 32'h0000_FFFF, r);
		rd(ADDR_CONTROL_ONE, v, r);
		chk(v, 32'h0000_3C67);
		wr(ADDR_CONTROL_TWO, 32'h0000_FFFF, r);
		rd(ADDR_CONTROL_TWO, v, r);
		chk(v, 32'h0000_01DF);
		wr(8'h10, 32'h0000_FFFF, r);
		chk(r, RESP_SLVERR);
		rd(8'h10, v, r);
		chk({r, v}, {RESP_SLVERR, 32'h0000_0000});
		wr(ADDR_CONTROL_ONE, 32'h0000_0000, r);
		wr(ADDR_CONTROL_TWO, 32'h0000_0000, r);
	endtask
	task automatic t_modes;
		int n[7] = '{4, 2, 4, 4, 16, 16, 4};
		int e[7] = '{0, 4, 4, 4, 4, 1, 0};
		// Last entry is the reserved mode, which must never capture
		for (int i = 0; i < 7; i++) begin
			cfg(16'(i), 16'h0001, 1);
			pin_u.pulse(n[i], 3);
			chk(irq_n, e[i]);
			rd(ADDR_CONTROL_ONE, v, r);
			chk(v[CTL1_BNE], e[i] != 0);
		end
	endtask
	task automatic t_values;
		cfg(16'h0823, 16'h0001, 1);
		tick(0, 3);
		repeat (5) begin
			tick(2, 1);
			pin_u.pulse(1, 3);
		end
		chk(irq_n, 2);
		rd(ADDR_CONTROL_ONE, v, r);
		chk(v, 32'h0000_083B);
		for (int k = 1; k < 5; k++) begin
			rd(ADDR_FIFO_LOW, v, r);
			chk(v, k);
			rd(ADDR_CONTROL_ONE, v, r);
			chk(v[4:3], k < 4);
		end
	endtask
	task automatic t_trigger;
		cfg(16'h0003, 16'h0083, 3);
		tick(0, 2);
		@(posedge clk);
		src_pulse <= 32'h0000_0008;
		@(posedge clk);
		src_pulse <= 32'h0000_0000;
		rd(ADDR_CONTROL_TWO, v, r);
		chk(v, 32'h0000_00C3);
		tick(0, 2);
		pin_u.pulse(1, 3);
		rd(ADDR_FIFO_LOW, v, r);
		chk(v, 2);
	endtask
	task automatic t_wake;
		cfg(16'h0007, 16'h0001, 1);
		sleep_req <= 1'h1;
		pin_u.pulse(1, 3);
		chk(irq_n, 1);
		sleep_req <= 1'h0;
		pin_u.pulse(1, 3);
		chk(irq_n, 1);
		// Idle wakes the same way as sleep
		idle_req <= 1'h1;
		pin_u.pulse(1, 3);
		chk(irq_n, 2);
		idle_req <= 1'h0;
	endtask
	// Low half wraps once, so both halves must read one
	task automatic t_cascade;
		cfg(16'h0003, 16'h0101, 1);
		@(posedge clk);
		tb_tick <= 8'h01;
		repeat (65537) @(posedge clk);
		tb_tick <= 8'h00;
		pin_u.pulse(1, 3);
		rd(ADDR_FIFO_LOW, v, r);
		chk(v, 1);
		rd(ADDR_FIFO_HIGH, v, r);
		chk(v, 1);
		rd(ADDR_CONTROL_ONE, v, r);
		chk(v, 3);
	endtask
	task automatic stop_test;
		$display("mismatches %0d compares %0d", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Reset, then the scenarios in order
	initial begin
		{rst_b, idle_req, sleep_req, s_axi_awvalid, s_axi_wvalid} = 5'h00;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
		{tb_tick, src_pulse, src_enabled} = 72'h00_0000_0000_0000_0000;
		ce = 1'h1;
		tb_enabled = 8'hFF;
		s_axi_wstrb = 4'hF;
		repeat (12) @(posedge clk);
		rst_b <= 1'h1;
		t_regs;
		t_modes;
		t_values;
		t_trigger;
		t_wake;
		t_cascade;
		stop_test;
	end
endmodule
bind edge_capture_unit edge_capture_unit_asserts chk_u (.*);
`default_nettype wire

/* verilog/capture_fifo_mem.sv */
`default_nettype none
module capture_fifo_mem (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [capture_pkg::FIFO_AW-1:0] wr_addr,
	input wire logic [capture_pkg::FIFO_DW-1:0] wr_data,
	input wire logic [capture_pkg::FIFO_AW-1:0] rd_addr,
	output logic [capture_pkg::FIFO_DW-1:0] rd_data
);
	import capture_pkg::*;

	logic [FIFO_DW-1:0] mem [0:(1<<FIFO_AW)-1];
	logic [FIFO_DW-1:0] rd_data_next;

	// Write-through so a word pushed into an empty store is readable at once
	always_comb begin
		rd_data_next = mem[rd_addr];
		if (wr_en && wr_addr == rd_addr) begin
			rd_data_next = wr_data;
		end
	end

	// Array holds no reset; only the output register does
	always_ff @(posedge clk) begin
		if (ce && wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data <= '0;
		end else if (ce) begin
			rd_data <= rd_data_next;
		end
	end
endmodule
`default_nettype wire

/* verilog/edge_capture_unit.sv */
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`default_nettype none
module edge_capture_unit (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic capture_input_pin,
	input wire logic idle_req,
	input wire logic sleep_req,
	input wire logic [7:0] tb_tick,
	input wire logic [7:0] tb_enabled,
	input wire logic [31:0] src_pulse,
	input wire logic [31:0] src_enabled,
	output logic capture_irq,
	input wire logic [capture_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [capture_pkg::AXI_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [capture_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [capture_pkg::AXI_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import capture_pkg::*;

	// Byte-lane merge of a 16-bit register, writable bits only
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
			input logic [3:0] strb, input logic [15:0] wmask);
		logic [15:0] m;
		m = wmask & {{8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (data[15:0] & m);
	endfunction

	// ==================================================
	// Declarations
	logic pin_meta_reg, pin_sync_reg, pin_prev_reg;
	logic [15:0] ctl1_reg, ctl1_next, ctl2_reg, ctl2_next;
	logic [31:0] count_reg, count_next;
	logic [3:0] pre_reg, pre_next;
	logic [1:0] ici_reg, ici_next;
	logic irq_reg, irq_next;
	logic [FIFO_AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	logic [2:0] fill_reg, fill_next;
	logic ovf_reg, ovf_next;
	logic [31:0] head_data;
	write_state_type wstate_reg, wstate_next;
	logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
	logic [7:0] waddr_reg, waddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic aw_have, w_have, do_write, ar_take;
	logic [7:0] wa;
	logic [31:0] wd;
	logic [3:0] ws;
	capture_mode_type mode;
	logic [2:0] tsel;
	logic [4:0] ssel;
	logic cascade, trig_mode, trig_stat, tb_ok, src_ok, src_fire;
	logic counting, sync_hold, rise, fall, edge_event, cap, push, pop, fifo_full, wake_irq;

	// ==================================================
	// Pin sampling: two stages, then the edge history
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_meta_reg <= 1'b0;
			pin_sync_reg <= 1'b0;
			pin_prev_reg <= 1'b0;
		end else if (ce) begin
			pin_meta_reg <= capture_input_pin;
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;
		end
	end

	assign rise = pin_sync_reg & ~pin_prev_reg;
	assign fall = ~pin_sync_reg & pin_prev_reg;

	// ==================================================
	// Field decode
	assign mode = capture_mode_type'(ctl1_reg[CTL1_MODE_LSB +: 3]);
	assign tsel = ctl1_reg[CTL1_TSEL_LSB +: 3];
	assign ssel = ctl2_reg[CTL2_SYNC_LSB +: 5];
	assign cascade = ctl2_reg[CTL2_CASCADE];
	assign trig_mode = ctl2_reg[CTL2_TRIG_MODE];
	assign trig_stat = ctl2_reg[CTL2_TRIG_STAT];
	// Reserved selections never count, so a bad setting cannot capture garbage
	assign tb_ok = tb_enabled[tsel] && tsel != TSEL_RSVD_A && tsel != TSEL_RSVD_B;
	assign src_ok = src_enabled[ssel];
	assign src_fire = src_pulse[ssel];
	// Sync mode keeps the count at zero until its source runs
	assign sync_hold = !trig_mode && !src_ok;

	// Counting gate: time base and source enabled, trigger seen, not halted
	assign counting = tb_ok && src_ok && (!trig_mode || trig_stat)
		&& !(idle_req && ctl1_reg[CTL1_IDLE_STOP]) && !sleep_req
		&& mode != MODE_OFF && mode != MODE_WAKE_PIN && mode != MODE_RESERVED;

	// ==================================================
	// Time base counter; one control set drives both halves when cascaded
	always_comb begin
		count_next = count_reg;
		if (sync_hold || (!trig_mode && src_fire)) begin
			count_next = '0;
		end else if (counting && tb_tick[tsel]) begin
			if (cascade) begin
				count_next = count_reg + 32'h0000_0001;
			end else begin
				count_next = {16'h0000, count_reg[15:0] + 16'h0001};
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count_reg <= '0;
		end else if (ce) begin
			count_reg <= count_next;
		end
	end

	// ==================================================
	// Event selection, prescaler and captures-per-interrupt
	always_comb begin
		edge_event = 1'b0;
		pre_next = pre_reg;
		unique case (mode)
			MODE_EVERY_EDGE: edge_event = rise | fall;
			MODE_FALLING: edge_event = fall;
			MODE_RISING: edge_event = rise;
			MODE_RISE_4: begin
				edge_event = rise && pre_reg == PRESCALE_4_LAST;
				if (rise) begin
					pre_next = (pre_reg == PRESCALE_4_LAST) ? 4'h0 : pre_reg + 4'h1;
				end
			end
			MODE_RISE_16: begin
				edge_event = rise && pre_reg == PRESCALE_16_LAST;
				if (rise) begin
					pre_next = pre_reg + 4'h1;
				end
			end
			MODE_OFF, MODE_RESERVED, MODE_WAKE_PIN: pre_next = 4'h0;
		endcase
	end

	assign cap = counting && edge_event;
	// Wake mode ignores every other setting and only flags a rising edge
	assign wake_irq = mode == MODE_WAKE_PIN && (sleep_req || idle_req) && rise;

	always_comb begin
		ici_next = ici_reg;
		irq_next = wake_irq;
		if (mode == MODE_OFF) begin
			ici_next = 2'h0;
		end else if (cap && mode == MODE_EVERY_EDGE) begin
			irq_next = 1'b1;
		end else if (cap) begin
			if (ici_reg == ctl1_reg[CTL1_ICI_LSB +: 2]) begin
				ici_next = 2'h0;
				irq_next = 1'b1;
			end else begin
				ici_next = ici_reg + 2'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_reg <= '0;
			ici_reg <= '0;
			irq_reg <= 1'b0;
		end else if (ce) begin
			pre_reg <= pre_next;
			ici_reg <= ici_next;
			irq_reg <= irq_next;
		end
	end

	assign capture_irq = irq_reg;

	// ==================================================
	// Capture store pointers and flags
	assign fifo_full = fill_reg == FIFO_DEPTH;
	assign push = cap && (!fifo_full || pop);

	always_comb begin
		wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
		rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
		fill_next = fill_reg + {2'b00, push} - {2'b00, pop};
		ovf_next = ovf_reg;
		// A lost capture sets the flag; freed space clears it; a capture meeting a pop is stored and the clear wins
		if (cap && fifo_full && !pop) begin
			ovf_next = 1'b1;
		end else if (pop) begin
			ovf_next = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			fill_reg <= '0;
			ovf_reg <= 1'b0;
		end else if (ce) begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			fill_reg <= fill_next;
			ovf_reg <= ovf_next;
		end
	end

	// Whole 32-bit value is stored; the high half is zero when not cascaded
	capture_fifo_mem u_store (
		.clk(clk),
		.rst_b(rst_b),
		.ce(ce),
		.wr_en(push),
		.wr_addr(wr_ptr_reg),
		.wr_data(count_reg),
		.rd_addr(rd_ptr_next),
		.rd_data(head_data)
	);

	// ==================================================
	// Bus write channel: address and data taken in either order
	assign s_axi_awready = ce && !aw_held_reg && wstate_reg == WR_COLLECT;
	assign s_axi_wready = ce && !w_held_reg && wstate_reg == WR_COLLECT;
	assign aw_have = aw_held_reg || (s_axi_awvalid && s_axi_awready);
	assign w_have = w_held_reg || (s_axi_wvalid && s_axi_wready);
	assign do_write = wstate_reg == WR_COLLECT && aw_have && w_have;
	assign wa = aw_held_reg ? waddr_reg : s_axi_awaddr;
	assign wd = w_held_reg ? wdata_reg : s_axi_wdata;
	assign ws = w_held_reg ? wstrb_reg : s_axi_wstrb;

	always_comb begin
		wstate_next = wstate_reg;
		aw_held_next = aw_held_reg;
		w_held_next = w_held_reg;
		waddr_next = waddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bresp_next = bresp_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_next = 1'b1;
			waddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_next = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
		end
		unique case (wstate_reg)
			WR_COLLECT: if (do_write) begin
				wstate_next = WR_RESP;
				aw_held_next = 1'b0;
				w_held_next = 1'b0;
				bresp_next = (wa <= ADDR_FIFO_HIGH && wa[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
			end
			WR_RESP: if (s_axi_bready) begin
				wstate_next = WR_COLLECT;
			end
		endcase
	end

	assign s_axi_bvalid = wstate_reg == WR_RESP;
	assign s_axi_bresp = bresp_reg;

	// ==================================================
	// Control registers; hardware trigger status set wins over a clear
	always_comb begin
		ctl1_next = ctl1_reg;
		ctl2_next = ctl2_reg;
		if (do_write && wa == ADDR_CONTROL_ONE) begin
			ctl1_next = merge16(ctl1_reg, wd, ws, CTL1_WMASK);
		end
		if (do_write && wa == ADDR_CONTROL_TWO) begin
			ctl2_next = merge16(ctl2_reg, wd, ws, CTL2_WMASK);
		end
		if (trig_mode && src_fire) begin
			ctl2_next[CTL2_TRIG_STAT] = 1'b1;
		end
	end

	// ==================================================
	// Bus read channel; a read of the oldest word's high half when cascaded, low half otherwise, pops the store
	assign s_axi_arready = ce && !rvalid_reg;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign pop = ar_take && fill_reg != 3'h0
		&& s_axi_araddr == (cascade ? ADDR_FIFO_HIGH : ADDR_FIFO_LOW);

	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		if (ar_take) begin
			rvalid_next = 1'b1;
			rresp_next = RESP_OKAY;
			rdata_next = '0;
			unique case (s_axi_araddr)
				ADDR_CONTROL_ONE: begin
					rdata_next[15:0] = ctl1_reg;
					rdata_next[CTL1_OVF] = ovf_reg;
					rdata_next[CTL1_BNE] = fill_reg != 3'h0;
				end
				ADDR_CONTROL_TWO: rdata_next[15:0] = ctl2_reg;
				ADDR_FIFO_LOW: rdata_next[15:0] = head_data[15:0];
				ADDR_FIFO_HIGH: rdata_next[15:0] = head_data[31:16];
				default: rresp_next = RESP_SLVERR;
			endcase
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// Register stage for the bus and control groups
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wstate_reg <= WR_COLLECT;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			waddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= RESP_OKAY;
			ctl1_reg <= CTL1_RESET;
			ctl2_reg <= CTL2_RESET;
		end else if (ce) begin
			wstate_reg <= wstate_next;
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			waddr_reg <= waddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
			ctl1_reg <= ctl1_next;
			ctl2_reg <= ctl2_next;
		end
	end
endmodule
`default_nettype wire
